/* File: logic/pmp_ctrl.sv */
// memory controller end: eight ports, storage, parity, interrupt cells
`timescale 1ns/1ps
module pmp_ctrl #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic                                   core_clk_in,
  input  wire logic                                   reset_n_in,
  input  wire logic                                   clk_en_in,
  input  wire logic [pmp_pkg::NUM_PORTS-1:0]          port_req_in,
  input  wire logic [pmp_pkg::NUM_INT_CELLS-1:0]      cell_clear_in,
  output logic [pmp_pkg::NUM_PORTS-1:0]               port_gnt_out,
  output logic [pmp_pkg::NUM_INT_CELLS-1:0]           cells_out,
  output logic                                        parity_err_out,
  pmp_mem_if.ctrl                                     mem
);
  typedef struct packed {
    logic [DEPTH-1:0][pmp_pkg::WORD_W:0]  store;
    logic                                 rvalid;
    logic [pmp_pkg::XFER_W-1:0]           rdata;
    logic [1:0]                           rpar;
    logic [pmp_pkg::NUM_INT_CELLS-1:0]    cells;
    logic                                 perr;
  } pmp_ctrl_s_t;

  pmp_ctrl_s_t s_r;
  pmp_ctrl_s_t s_nxt;
  logic [pmp_pkg::NUM_PORTS-1:0] reqs;
  logic [pmp_pkg::NUM_PORTS-1:0] gnts;
  logic [1:0] wpar_chk;
  logic [AW-1:0] idx;

  // processor occupies port 0, lowest number wins
  assign reqs = {port_req_in[pmp_pkg::NUM_PORTS-1:1], mem.req};
  assign gnts = reqs & (~reqs + 1'b1);
  assign idx = mem.addr[AW-1:0]; // low bits pick the slot, successive pairs spread

  for (genvar g = 0; g < 2; g++) begin : g_par
    pmp_parity #(.W(pmp_pkg::WORD_W)) u_p (
      .word_in (mem.wdata[g*pmp_pkg::WORD_W +: pmp_pkg::WORD_W]),
      .par_out (wpar_chk[g])
    );
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.perr = 1'b0;
    if (gnts[0]) begin
      if (mem.we) begin
        s_nxt.store[idx] = {mem.wpar[0], mem.wdata[pmp_pkg::WORD_W-1:0]};
        s_nxt.store[AW'(idx + 1'b1)] = {mem.wpar[1], mem.wdata[pmp_pkg::XFER_W-1:pmp_pkg::WORD_W]};
        s_nxt.perr = (wpar_chk != mem.wpar);
      end else begin
        s_nxt.rvalid = 1'b1;
        s_nxt.rdata = {s_r.store[AW'(idx + 1'b1)][pmp_pkg::WORD_W-1:0],
                       s_r.store[idx][pmp_pkg::WORD_W-1:0]};
        s_nxt.rpar = {s_r.store[AW'(idx + 1'b1)][pmp_pkg::WORD_W],
                      s_r.store[idx][pmp_pkg::WORD_W]};
      end
    end
    // set wins over clear
    s_nxt.cells = (s_r.cells & ~cell_clear_in);
    if (mem.cell_set) begin
      s_nxt.cells[mem.cell_idx] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_r <= '0;
    end else if (clk_en_in) begin
      s_r <= s_nxt;
    end
  end

  assign mem.gnt = gnts[0];
  assign mem.rvalid = s_r.rvalid;
  assign mem.rdata = s_r.rdata;
  assign mem.rpar = s_r.rpar;
  assign mem.irq = |s_r.cells;
  assign port_gnt_out = gnts;
  assign cells_out = s_r.cells;
  assign parity_err_out = s_r.perr;
endmodule : pmp_ctrl

/* File: logic/pmp_mem_if.sv */
// processor to memory controller port signals
`timescale 1ns/1ps
interface pmp_mem_if;
  logic                         req;
  logic                         gnt;
  logic                         we;
  logic [pmp_pkg::ADDR_W-1:0]   addr;
  logic [pmp_pkg::XFER_W-1:0]   wdata;
  logic [1:0]                   wpar;
  logic                         rvalid;
  logic [pmp_pkg::XFER_W-1:0]   rdata;
  logic [1:0]                   rpar;
  logic                         cell_set;
  logic [4:0]                   cell_idx;
  logic                         irq;

  modport proc (output req, we, addr, wdata, wpar, cell_set, cell_idx,
                input gnt, rvalid, rdata, rpar, irq);
  modport ctrl (input req, we, addr, wdata, wpar, cell_set, cell_idx,
                output gnt, rvalid, rdata, rpar, irq);
endinterface : pmp_mem_if

/* File: logic/pmp_parity.sv */
// parity over one stored word, odd sense chosen so all-zero is flagged
`timescale 1ns/1ps
module pmp_parity #(
  parameter int W = 36
) (
  input  wire logic [W-1:0] word_in,
  output logic              par_out
);
  assign par_out = ~(^word_in);
endmodule : pmp_parity

/* File: logic/pmp_pkg.sv */
// shared constants and types for the processor mode protection block
package pmp_pkg;
  localparam int WORD_W        = 36;
  localparam int PAR_W         = 1;
  localparam int XFER_W        = 72;
  localparam int BLOCK_WORDS   = 1024;
  localparam int BLOCK_SHIFT   = 10;
  localparam int MODULE_WORDS  = 131072;
  localparam int SYSTEM_WORDS  = 262144;
  localparam int ADDR_W        = 18;
  localparam int BLKCNT_W      = 9;
  localparam int NUM_PORTS     = 8;
  localparam int NUM_INT_CELLS = 32;
  localparam int NUM_FAULTS    = 16;
  localparam int FAULT_W       = 4;
  localparam int TIMER_W       = 24;
  localparam logic [FAULT_W-1:0] FLT_OVERFLOW = 4'h0;
  localparam logic [FAULT_W-1:0] FLT_TIMER    = 4'h1;
  localparam logic [FAULT_W-1:0] FLT_BOUNDS   = 4'h2;
  localparam logic [FAULT_W-1:0] FLT_MASTER   = 4'h3;
  localparam logic [FAULT_W-1:0] FLT_CMD      = 4'h4;
  localparam logic [FAULT_W-1:0] FLT_PARITY   = 4'h5;
  localparam logic [ADDR_W-1:0]  VEC_BASE     = 18'h0_0000;
  localparam logic [TIMER_W-1:0] TIMER_RST    = 24'h00_0000;
  localparam logic [ADDR_W-1:0]  BASE_RST     = 18'h0_0000;
  localparam logic [BLKCNT_W-1:0] SIZE_RST    = 9'h000;

  typedef enum logic [1:0] {
    PMP_OP_READ,
    PMP_OP_WRITE,
    PMP_OP_LOAD_BASE,
    PMP_OP_LOAD_TIMER
  } pmp_op_t;
endpackage : pmp_pkg

/* File: logic/pmp_proc.sv */
// processor end: modes, relocation, bounds, timer, fault vectoring
//
// What this block does
// - two states: supervisor and user
// - supervisor: any address, io, control writes
// - user references relative to base register
// - user control commands refused with fault
// - supervisor bypasses relocation and bounds
// - base register: start and block count
// - in bounds: add base, then access
// - out of bounds: abandon, trap to supervisor
// - timer expiry raises fault
// - timer loadable only in supervisor
// - sixteen faults, each own vector
// - overflow, timer, bounds, master entry faults
// - memory word is 36 bits plus parity
// - 1024-word blocks, module and system limits
// - controller ranks eight ports by number
// - controller holds 32 interrupt cells
// - every transfer moves 72 bits
// - memory controller is only outside path
// - control unit checks, operations unit computes
// - controller keeps all words in one store indexed by low address bits
`timescale 1ns/1ps
module pmp_proc #(
  parameter int TW = pmp_pkg::TIMER_W
) (
  input  wire logic                          core_clk_in,
  input  wire logic                          reset_n_in,
  input  wire logic                          clk_en_in,
  input  wire logic                          cmd_valid_in,
  input  wire pmp_pkg::pmp_op_t              cmd_op_in,
  input  wire logic [pmp_pkg::ADDR_W-1:0]    cmd_addr_in,
  input  wire logic [pmp_pkg::XFER_W-1:0]    cmd_wdata_in,
  input  wire logic [pmp_pkg::BLKCNT_W-1:0]  cmd_size_in,
  input  wire logic [TW-1:0]                 cmd_timer_in,
  input  wire logic                          overflow_in,
  input  wire logic                          master_entry_in,
  output logic                               cmd_ready_out,
  output logic                               done_out,
  output logic [pmp_pkg::XFER_W-1:0]         rdata_out,
  output logic                               fault_out,
  output logic [pmp_pkg::FAULT_W-1:0]        fault_code_out,
  output logic [pmp_pkg::ADDR_W-1:0]         fault_vector_out,
  output logic                               supervisor_out,
  output logic [pmp_pkg::ADDR_W-1:0]         base_out,
  output logic [pmp_pkg::BLKCNT_W-1:0]       size_out,
  pmp_mem_if.proc                            mem
);
  typedef enum logic [1:0] {PMP_IDLE, PMP_REQ, PMP_WAIT} pmp_state_t;

  typedef struct packed {
    pmp_state_t                     st;
    logic                           sup;
    logic [pmp_pkg::ADDR_W-1:0]     base;
    logic [pmp_pkg::BLKCNT_W-1:0]   size;
    logic [TW-1:0]                  timer;
    logic                           timer_run;
    logic                           we;
    logic [pmp_pkg::ADDR_W-1:0]     addr;
    logic [pmp_pkg::XFER_W-1:0]     wdata;
    logic [pmp_pkg::XFER_W-1:0]     rdata;
    logic                           done;
    logic                           fault;
    logic [pmp_pkg::FAULT_W-1:0]    code;
  } pmp_proc_s_t;

  pmp_proc_s_t s_r;
  pmp_proc_s_t s_nxt;

  logic [1:0] wpar;
  logic [1:0] rpar_calc;
  logic [pmp_pkg::ADDR_W:0] limit;
  logic in_bounds;
  logic is_mem;

  for (genvar g = 0; g < 2; g++) begin : g_par
    pmp_parity #(.W(pmp_pkg::WORD_W)) u_wp (
      .word_in (s_r.wdata[g*pmp_pkg::WORD_W +: pmp_pkg::WORD_W]),
      .par_out (wpar[g])
    );
    pmp_parity #(.W(pmp_pkg::WORD_W)) u_rp (
      .word_in (mem.rdata[g*pmp_pkg::WORD_W +: pmp_pkg::WORD_W]),
      .par_out (rpar_calc[g])
    );
  end

  // size in blocks to word limit
  assign limit = {s_r.size, {pmp_pkg::BLOCK_SHIFT{1'b0}}};
  assign in_bounds = ({1'b0, cmd_addr_in} < limit);
  assign is_mem = (cmd_op_in == pmp_pkg::PMP_OP_READ) || (cmd_op_in == pmp_pkg::PMP_OP_WRITE);

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.fault = 1'b0;
    if (s_r.timer_run) begin
      if (s_r.timer == '0) begin
        s_nxt.timer_run = 1'b0;
        s_nxt.fault = 1'b1;
        s_nxt.code = pmp_pkg::FLT_TIMER;
      end else begin
        s_nxt.timer = s_r.timer - 1'b1;
      end
    end
    case (s_r.st)
      PMP_IDLE: begin
        if (s_nxt.fault) begin
          // timer fault wins this cycle
        end else if (overflow_in) begin
          s_nxt.fault = 1'b1;
          s_nxt.code = pmp_pkg::FLT_OVERFLOW;
        end else if (master_entry_in) begin
          s_nxt.fault = 1'b1;
          s_nxt.code = pmp_pkg::FLT_MASTER;
        end else if (cmd_valid_in) begin
          if (!is_mem && !s_r.sup) begin
            s_nxt.fault = 1'b1;
            s_nxt.code = pmp_pkg::FLT_CMD;
          end else if (cmd_op_in == pmp_pkg::PMP_OP_LOAD_BASE) begin
            s_nxt.base = cmd_addr_in;
            s_nxt.size = cmd_size_in;
            s_nxt.done = 1'b1;
          end else if (cmd_op_in == pmp_pkg::PMP_OP_LOAD_TIMER) begin
            s_nxt.timer = cmd_timer_in;
            s_nxt.timer_run = 1'b1;
            s_nxt.sup = 1'b0; // timer load hands control to the user program
            s_nxt.done = 1'b1;
          end else if (s_r.sup) begin
            s_nxt.addr = cmd_addr_in;
            s_nxt.we = (cmd_op_in == pmp_pkg::PMP_OP_WRITE);
            s_nxt.wdata = cmd_wdata_in;
            s_nxt.st = PMP_REQ;
          end else if (in_bounds) begin
            s_nxt.addr = cmd_addr_in + s_r.base;
            s_nxt.we = (cmd_op_in == pmp_pkg::PMP_OP_WRITE);
            s_nxt.wdata = cmd_wdata_in;
            s_nxt.st = PMP_REQ;
          end else begin
            s_nxt.fault = 1'b1;
            s_nxt.code = pmp_pkg::FLT_BOUNDS;
          end
        end
      end
      PMP_REQ: begin
        if (mem.gnt) begin
          s_nxt.st = s_r.we ? PMP_IDLE : PMP_WAIT;
          s_nxt.done = s_r.we;
        end
      end
      PMP_WAIT: begin
        if (mem.rvalid) begin
          s_nxt.st = PMP_IDLE;
          s_nxt.rdata = mem.rdata;
          if (rpar_calc != mem.rpar) begin
            s_nxt.fault = 1'b1;
            s_nxt.code = pmp_pkg::FLT_PARITY;
          end else begin
            s_nxt.done = 1'b1;
          end
        end
      end
      default: s_nxt.st = PMP_IDLE;
    endcase
    if (s_nxt.fault) begin
      s_nxt.sup = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_r <= '{st: PMP_IDLE, sup: 1'b1, base: pmp_pkg::BASE_RST, size: pmp_pkg::SIZE_RST,
               timer: pmp_pkg::TIMER_RST, timer_run: 1'b0, we: 1'b0,
               addr: '0, wdata: '0, rdata: '0, done: 1'b0, fault: 1'b0,
               code: '0};
    end else if (clk_en_in) begin
      s_r <= s_nxt;
    end
  end

  // this control unit issues all memory traffic
  assign mem.req = (s_r.st == PMP_REQ);
  assign mem.we = s_r.we;
  assign mem.addr = s_r.addr;
  assign mem.wdata = s_r.wdata;
  assign mem.wpar = wpar;
  assign mem.cell_set = 1'b0;
  assign mem.cell_idx = 5'h00;

  assign cmd_ready_out = (s_r.st == PMP_IDLE);
  assign done_out = s_r.done;
  assign rdata_out = s_r.rdata;
  assign fault_out = s_r.fault;
  assign fault_code_out = s_r.code;
  assign fault_vector_out = pmp_pkg::VEC_BASE + {{(pmp_pkg::ADDR_W-pmp_pkg::FAULT_W){1'b0}}, s_r.code};
  assign supervisor_out = s_r.sup;
  assign base_out = s_r.base;
  assign size_out = s_r.size;
endmodule : pmp_proc

/* File: tb/pmp_monitor.sv */
// interface checker for the processor to memory port
`timescale 1ns/1ps
module pmp_monitor (
  input wire logic                       core_clk_in,
  input wire logic                       reset_n_in,
  input wire logic                       req,
  input wire logic                       gnt,
  input wire logic                       we,
  input wire logic [pmp_pkg::XFER_W-1:0] wdata,
  input wire logic [1:0]                 wpar,
  input wire logic                       rvalid,
  input wire logic [pmp_pkg::XFER_W-1:0] rdata,
  input wire logic [1:0]                 rpar,
  input wire logic                       cell_set,
  input wire logic                       irq
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  a_read_answer: assert property (req && gnt && !we |=> rvalid)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (rvalid |-> $past(req && gnt && !we))
    else $error("read data without a granted read");
  a_write_quiet: assert property (req && gnt && we |=> !rvalid)
    else $error("write gave read data");
  a_write_parity: assert property (req && we |-> wpar == {~^wdata[71:36], ~^wdata[35:0]})
    else $error("write parity wrong");
  a_read_parity: assert property (rvalid |-> rpar == {~^rdata[71:36], ~^rdata[35:0]})
    else $error("read parity wrong");
  a_port0_first: assert property (req |-> gnt)
    else $error("port 0 not granted");
  a_one_request: assert property (req && gnt |=> !req)
    else $error("request repeated after grant");
  a_irq_cause: assert property (!cell_set |=> !$rose(irq))
    else $error("interrupt without cell set");
  c_write: cover property (req && gnt && we);
  c_read: cover property (rvalid);
  c_back2back: cover property (req ##2 req);
endmodule : pmp_monitor

/* File: tb/tb_top.sv */
// self-checking bench joining processor end and controller end
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst_n = 0, valid = 0, ovf = 0, mst = 0, ready, done, fault, sup, perr;
  pmp_pkg::pmp_op_t op = pmp_pkg::PMP_OP_READ;
  logic [17:0] addr = '0, vec, base;
  logic [71:0] wdata = '0, rdata;
  logic [8:0] size = '0, size_o;
  logic [23:0] timer = '0;
  logic [3:0] code;
  logic [7:0] port_req = '0, gnt;
  logic [31:0] cell_clr = '0, cells;
  int mismatches = 0;
  int n_compared = 0;
  pmp_mem_if mem_bus ();
  pmp_proc i_pmp_proc (.core_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(1'b1),
    .cmd_valid_in(valid), .cmd_op_in(op), .cmd_addr_in(addr), .cmd_wdata_in(wdata),
    .cmd_size_in(size), .cmd_timer_in(timer), .overflow_in(ovf), .master_entry_in(mst),
    .cmd_ready_out(ready), .done_out(done), .rdata_out(rdata), .fault_out(fault),
    .fault_code_out(code), .fault_vector_out(vec), .supervisor_out(sup), .base_out(base),
    .size_out(size_o), .mem(mem_bus));
  pmp_ctrl i_pmp_ctrl (.core_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(1'b1),
    .port_req_in(port_req), .cell_clear_in(cell_clr), .port_gnt_out(gnt),
    .cells_out(cells), .parity_err_out(perr), .mem(mem_bus));
  pmp_monitor i_pmp_monitor (.core_clk_in(clk), .reset_n_in(rst_n), .req(mem_bus.req),
    .gnt(mem_bus.gnt), .we(mem_bus.we), .wdata(mem_bus.wdata), .wpar(mem_bus.wpar),
    .rvalid(mem_bus.rvalid), .rdata(mem_bus.rdata), .rpar(mem_bus.rpar),
    .cell_set(mem_bus.cell_set), .irq(mem_bus.irq));
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic issue(input pmp_pkg::pmp_op_t o, input logic [17:0] a, input logic [71:0] d,
                       input logic [8:0] s, input logic [23:0] t);
    @(posedge clk);
    valid <= 1'b1;
    op <= o;
    addr <= a;
    wdata <= d;
    size <= s;
    timer <= t;
    do @(posedge clk); while (ready !== 1'b1);
    valid <= 1'b0;
  endtask : issue
  task automatic cmd(input pmp_pkg::pmp_op_t o, input logic [17:0] a, input logic [71:0] d,
                     input logic [8:0] s, input logic [23:0] t);
    int n;
    issue(o, a, d, s, t);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && fault !== 1'b1 && n < 20);
    check(72'(done), 72'h1);
  endtask : cmd
  task automatic wfault(input logic [3:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(fault === 1'b1 && code === exp) && n < 40);
    check(72'(code), 72'(exp));
    check(72'(vec), 72'(pmp_pkg::VEC_BASE + 18'(exp)));
    check(72'(sup), 72'h1);
  endtask : wfault
  task automatic sc_mem;
    logic [71:0] d0 = 72'hA5_5A5A_5A5A_F0F0_F0F0;
    cmd(pmp_pkg::PMP_OP_WRITE, 18'h3_FFF0, d0, 9'h000, 24'h00_0000);
    cmd(pmp_pkg::PMP_OP_WRITE, 18'h0_0004, 72'h0, 9'h000, 24'h00_0000);
    cmd(pmp_pkg::PMP_OP_READ, 18'h3_FFF0, 72'h0, 9'h000, 24'h00_0000);
    check(rdata, d0);
    cmd(pmp_pkg::PMP_OP_READ, 18'h0_0004, d0, 9'h000, 24'h00_0000);
    check(rdata, 72'h0);
  endtask : sc_mem
  task automatic sc_user;
    logic [71:0] d1 = 72'h12_3456_789A_BCDE_F012;
    cmd(pmp_pkg::PMP_OP_WRITE, 18'h0_0410, d1, 9'h000, 24'h00_0000);
    cmd(pmp_pkg::PMP_OP_LOAD_BASE, 18'h0_0400, 72'h0, 9'h003, 24'h00_0000);
    cmd(pmp_pkg::PMP_OP_LOAD_TIMER, 18'h0_0000, 72'h0, 9'h000, 24'h00_0100);
    check(72'(sup), 72'h0);
    cmd(pmp_pkg::PMP_OP_READ, 18'h0_0010, 72'h0, 9'h000, 24'h00_0000);
    check(rdata, d1);
    issue(pmp_pkg::PMP_OP_WRITE, 18'h0_0C10, 72'h0, 9'h000, 24'h00_0000);
    wfault(pmp_pkg::FLT_BOUNDS);
    cmd(pmp_pkg::PMP_OP_READ, 18'h0_0410, 72'h0, 9'h000, 24'h00_0000);
    check(rdata, d1);
    cmd(pmp_pkg::PMP_OP_LOAD_TIMER, 18'h0_0000, 72'h0, 9'h000, 24'h00_0100);
    issue(pmp_pkg::PMP_OP_LOAD_BASE, 18'h0_0800, 72'h0, 9'h001, 24'h00_0000);
    wfault(pmp_pkg::FLT_CMD);
    check(72'(base), 72'h400);
  endtask : sc_user
  task automatic sc_control;
    cmd(pmp_pkg::PMP_OP_LOAD_BASE, 18'h0_0400, 72'h0, 9'h003, 24'h00_0000);
    check(72'(base), 72'h400);
    check(72'(size_o), 72'h3);
    cmd(pmp_pkg::PMP_OP_LOAD_TIMER, 18'h0_0000, 72'h0, 9'h000, 24'h00_0005);
    wfault(pmp_pkg::FLT_TIMER);
  endtask : sc_control
  task automatic sc_faults;
    @(posedge clk);
    ovf <= 1'b1;
    mst <= 1'b1;
    wfault(pmp_pkg::FLT_OVERFLOW);
    @(posedge clk);
    ovf <= 1'b0;
    wfault(pmp_pkg::FLT_MASTER);
    @(posedge clk);
    mst <= 1'b0;
  endtask : sc_faults
  task automatic sc_ports;
    logic [7:0] rq [3] = '{8'hF0, 8'hA6, 8'h80};
    logic [7:0] ex [3] = '{8'h10, 8'h02, 8'h80};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      port_req <= rq[i];
      cell_clr <= {32{i[0]}};
      @(negedge clk);
      check(72'(gnt), 72'(ex[i]));
      check(72'(cells), 72'h0);
    end
    port_req <= 8'h00;
  endtask : sc_ports
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial forever #5 clk = ~clk;
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(72'(sup), 72'h1);
    check(72'(base), 72'h0);
    sc_mem();
    sc_user();
    sc_control();
    sc_faults();
    sc_ports();
    tally_and_finish();
  end
endmodule : tb_top
